/* rtl/bcm_pkg.sv */
// constants, types and state layout of the boot code memory mapper
// What this block does
// - boot ROM 0x0000-0x07FF, flash spans 0x0000-0xFFFF
// - every reset starts execution from boot ROM
// - boot select high runs programming routine
// - boot select low branches to entry stub
// - initially flash in data space, writable, unexecutable
// - ROM and stub overlay flash while mapped
// - stub unmaps ROM, maps flash, jumps 0x0000
// - writing zero to map bit unmaps stub
// - memory lock blocks external access and debugger
package bcm_pkg;
  localparam logic [7:0]  BCM_CFG_ADDR    = 8'hFF;
  localparam logic [7:0]  BCM_CFG_RESET   = 8'h00;
  localparam int          BCM_STUB_MAP_POS = 7;
  localparam int          BCM_ISP_EN_POS  = 6;
  localparam int          BCM_EM_MSB      = 5;
  localparam int          BCM_EM_LSB      = 3;
  localparam int          BCM_FB_POS      = 1;
  localparam int          BCM_BE_POS      = 0;
  localparam logic [15:0] BCM_ROM_FIRST   = 16'h0000;
  localparam logic [15:0] BCM_ROM_LAST    = 16'h07FF;
  localparam logic [15:0] BCM_STUB_FIRST  = 16'hFFF7;
  localparam logic [15:0] BCM_STUB_LAST   = 16'hFFFF;
  localparam logic [15:0] BCM_APP_START   = 16'h0000;
  localparam logic [1:0]  BCM_SETTLE_CNT  = 2'h2;

  typedef enum logic [1:0] { BCM_BOOT, BCM_ISP, BCM_ENTRY, BCM_APP } bcm_phase_t;
  typedef enum logic [1:0] { BCM_SEL_NONE, BCM_SEL_ROM, BCM_SEL_STUB, BCM_SEL_FLASH } bcm_src_t;

  typedef struct packed {
    bcm_phase_t  phase;
    logic        ispRun;
    logic [1:0]  pinSync;
    logic [1:0]  settle;
    logic        bootSel;
    logic [7:0]  cfg;
    logic        romMapped;
    logic        stubMapped;
    logic        flashInCode;
    bcm_src_t    fetchSel;
    logic        fetchValid;
    logic        dataFlashSel;
    logic        flashWrEn;
    logic [7:0]  sfrRdata;
    logic        jumpReq;
    logic        extAccessEn;
    logic        debugEn;
  } bcm_state_t;
endpackage : bcm_pkg

/* rtl/bcm_mapper.sv */
// code memory map controller: boot ROM, entry stub and code flash steering
`timescale 1ns/1ps
module bcm_mapper
  import bcm_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // board pin
  input  wire logic        bootSelectPin,
  // core code fetch
  input  wire logic        fetchReq,
  input  wire logic [15:0] fetchAddr,
  // core data access
  input  wire logic        dataReq,
  input  wire logic        dataWe,
  input  wire logic [15:0] dataAddr,
  // core special register path
  input  wire logic        sfrWe,
  input  wire logic        sfrRe,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [7:0]  sfrWdata,
  // entry stub remap strobe
  input  wire logic        remapReq,
  // on-chip status
  input  wire logic        flashBusy,
  input  wire logic        memLock,
  // map results
  output logic [1:0]       fetchSel,
  output logic             fetchValid,
  output logic             dataFlashSel,
  output logic             flashWrEn,
  // register read data
  output logic [7:0]       sfrRdata,
  // boot flow
  output logic [1:0]       bootPhase,
  output logic             ispRun,
  output logic             jumpReq,
  output logic [15:0]      jumpAddr,
  // lock gating
  output logic             extAccessEn,
  output logic             debugEn
);

  bcm_state_t st;
  bcm_state_t next_st;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.jumpReq = 1'b0;
    // two-flop sync; only the second stage is read
    next_st.pinSync = {st.pinSync[0], bootSelectPin};
    // boot flow: choose only after the sync chain has filled
    case (st.phase)
      BCM_BOOT: begin
        if (st.settle != BCM_SETTLE_CNT) begin
          next_st.settle = st.settle + 2'h1;
        end else begin
          next_st.bootSel = st.pinSync[1];
          next_st.phase = st.pinSync[1] ? BCM_ISP : BCM_ENTRY;
        end
      end
      BCM_ISP: begin
        next_st.phase = BCM_ISP;
      end
      BCM_ENTRY: begin
        // remap only honoured while the stub itself is running
        if (remapReq) begin
          next_st.romMapped = 1'b0;
          next_st.flashInCode = 1'b1;
          next_st.jumpReq = 1'b1;
          next_st.phase = BCM_APP;
        end
      end
      BCM_APP: begin
        next_st.phase = BCM_APP;
      end
      default: begin
        next_st.phase = BCM_BOOT;
      end
    endcase
    // configuration register written by the core
    if (sfrWe && sfrAddr == BCM_CFG_ADDR) begin
      next_st.cfg[BCM_STUB_MAP_POS] = sfrWdata[BCM_STUB_MAP_POS];
      next_st.cfg[BCM_ISP_EN_POS] = sfrWdata[BCM_ISP_EN_POS];
      next_st.cfg[BCM_EM_MSB:BCM_EM_LSB] = sfrWdata[BCM_EM_MSB:BCM_EM_LSB];
      if (!sfrWdata[BCM_STUB_MAP_POS]) begin
        next_st.stubMapped = 1'b0;
      end
    end
    // register read, reserved bit reads zero, status bits live
    next_st.sfrRdata = 8'h00;
    if (sfrRe && sfrAddr == BCM_CFG_ADDR) begin
      next_st.sfrRdata = st.cfg;
      next_st.sfrRdata[BCM_FB_POS] = flashBusy;
      next_st.sfrRdata[BCM_BE_POS] = st.bootSel;
    end
    // code fetch decode: overlays win over flash
    next_st.fetchValid = fetchReq;
    next_st.fetchSel = BCM_SEL_NONE;
    if (fetchReq) begin
      if (st.romMapped && fetchAddr <= BCM_ROM_LAST) begin
        next_st.fetchSel = BCM_SEL_ROM;
      end else if (st.stubMapped && fetchAddr >= BCM_STUB_FIRST) begin
        next_st.fetchSel = BCM_SEL_STUB;
      end else if (st.flashInCode) begin
        next_st.fetchSel = BCM_SEL_FLASH;
      end
    end
    // flash is a data-space target only until it moves to code space
    next_st.dataFlashSel = dataReq && !st.flashInCode;
    next_st.flashWrEn = dataReq && dataWe && !st.flashInCode;
    // lock gates outside access and the debugger
    next_st.extAccessEn = !memLock;
    next_st.debugEn = !memLock;
    // phase decode held in a flop so the port comes straight from a register
    next_st.ispRun = (next_st.phase == BCM_ISP);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset brings back the boot ROM map
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st.phase <= BCM_BOOT;
      st.ispRun <= 1'b0;
      st.pinSync <= 2'h0;
      st.settle <= 2'h0;
      st.bootSel <= 1'b0;
      st.cfg <= BCM_CFG_RESET;
      st.romMapped <= 1'b1;
      st.stubMapped <= 1'b1;
      st.flashInCode <= 1'b0;
      st.fetchSel <= BCM_SEL_NONE;
      st.fetchValid <= 1'b0;
      st.dataFlashSel <= 1'b0;
      st.flashWrEn <= 1'b0;
      st.sfrRdata <= 8'h00;
      st.jumpReq <= 1'b0;
      st.extAccessEn <= 1'b0;
      st.debugEn <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops, except jumpAddr tied to BCM_APP_START
  assign fetchSel     = st.fetchSel;
  assign fetchValid   = st.fetchValid;
  assign dataFlashSel = st.dataFlashSel;
  assign flashWrEn    = st.flashWrEn;
  assign sfrRdata     = st.sfrRdata;
  assign bootPhase    = st.phase;
  assign ispRun       = st.ispRun;
  assign jumpReq      = st.jumpReq;
  assign jumpAddr     = BCM_APP_START;
  assign extAccessEn  = st.extAccessEn;
  assign debugEn      = st.debugEn;

  ////////////////////////////////////////////////////////////////////////
  // checks
  rom_window_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.romMapped && fetchReq && fetchAddr <= 16'h07FF) |=> (fetchSel == BCM_SEL_ROM))
    else $error("low fetch not sent to boot rom");

  rom_after_boot_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.phase == BCM_BOOT) |-> (st.romMapped && !st.flashInCode))
    else $error("boot phase without rom map");

  isp_path_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.phase == BCM_BOOT && st.settle == 2'h2 && st.pinSync[1]) |=> (ispRun && st.bootSel))
    else $error("high boot select did not start isp");

  entry_path_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.phase == BCM_BOOT && st.settle == 2'h2 && !st.pinSync[1]) |=> (bootPhase == BCM_ENTRY && !ispRun))
    else $error("low boot select did not reach entry stub");

  flash_data_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (!st.flashInCode && dataReq && dataWe) |=> (flashWrEn && dataFlashSel && fetchSel != BCM_SEL_FLASH))
    else $error("initial flash map wrong");

  stub_window_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.stubMapped && fetchReq && fetchAddr >= 16'hFFF7 && !(st.romMapped && fetchAddr <= 16'h07FF))
    |=> (fetchSel == BCM_SEL_STUB))
    else $error("top fetch not sent to stub");

  remap_jump_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.phase == BCM_ENTRY && remapReq) |=> (jumpReq && jumpAddr == 16'h0000 && !st.romMapped
    && st.flashInCode) ##1 !jumpReq)
    else $error("remap did not move flash or jump");

  stub_unmap_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (sfrWe && sfrAddr == 8'hFF && !sfrWdata[7]) |=> (!st.stubMapped && !st.cfg[7]))
    else $error("map bit write did not unmap stub");

  lock_gate_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    memLock |=> (!extAccessEn && !debugEn))
    else $error("lock did not block access");

  top_flash_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (!st.stubMapped && st.flashInCode && fetchReq && fetchAddr >= 16'hFFF7) |=> (fetchSel == BCM_SEL_FLASH))
    else $error("top fetch not from flash after unmap");

  cfg_write_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (sfrWe && sfrAddr == 8'hFF) |=> (st.cfg[6:3] == $past(sfrWdata[6:3])))
    else $error("config write lost");

  fetch_valid_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    fetchReq |=> fetchValid)
    else $error("fetch request not answered");

  sfr_other_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (sfrRe && sfrAddr != 8'hFF) |=> (sfrRdata == 8'h00))
    else $error("foreign register read not zero");

  cfg_read_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (sfrRe && sfrAddr == 8'hFF) |=> (!sfrRdata[2] && sfrRdata[0] == $past(st.bootSel)))
    else $error("config read layout wrong");

  data_refused_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.flashInCode && dataReq) |=> (!dataFlashSel && !flashWrEn))
    else $error("flash still in data space after remap");

  isp_hold_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.phase == BCM_ISP && remapReq) |=> (ispRun && !jumpReq))
    else $error("remap honoured outside entry stub");

endmodule : bcm_mapper

/* verification/bcm_core_model.sv */
// processor core model issuing code, data and register requests
`timescale 1ns/1ps
module bcm_core_model (
  // clock
  input  wire logic        sys_clk,
  // requests toward the mapper
  output logic             fetchReq,
  output logic [15:0]      fetchAddr,
  output logic             dataReq,
  output logic             dataWe,
  output logic [15:0]      dataAddr,
  output logic             sfrWe,
  output logic             sfrRe,
  output logic [7:0]       sfrAddr,
  output logic [7:0]       sfrWdata,
  output logic             remapReq
);
  ////////////////////////////////
  // idle at time zero
  initial begin
    {remapReq, fetchReq, dataReq, dataWe, sfrWe, sfrRe} = 6'h00;
    {fetchAddr, dataAddr, sfrAddr, sfrWdata} = 48'h0;
  end
  // one request held for one edge; released lines invert so stale values never match
  task automatic go(input logic [5:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    {remapReq, fetchReq, dataReq, dataWe, sfrWe, sfrRe} = k;
    {fetchAddr, dataAddr, sfrAddr, sfrWdata} = {a, a, a[7:0], d};
    @(posedge sys_clk);
    #1;
    {remapReq, fetchReq, dataReq, dataWe, sfrWe, sfrRe} = 6'h00;
    {fetchAddr, dataAddr, sfrAddr, sfrWdata} = ~{a, a, a[7:0], d};
  endtask : go
endmodule : bcm_core_model

/* verification/boot_code_memory_mapper_tb.sv */
// self-checking bench for the code memory map controller
`timescale 1ns/1ps
module boot_code_memory_mapper_tb import bcm_pkg::*;;
  logic        sys_clk = 1'b0, rstn = 1'b0, bootSelectPin = 1'b0, flashBusy = 1'b0, memLock = 1'b0;
  logic        fetchReq, dataReq, dataWe, sfrWe, sfrRe, remapReq, fetchValid, dataFlashSel;
  logic        flashWrEn, ispRun, jumpReq, extAccessEn, debugEn;
  logic [15:0] fetchAddr, dataAddr, jumpAddr;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, cfgVal;
  logic [1:0]  fetchSel, bootPhase;
  int          nMismatch = 0;
  int          checks = 0;
  localparam logic [5:0] K_REMAP = 6'h20, K_FETCH = 6'h10, K_DWR = 6'h0C, K_DRD = 6'h08, K_WR = 6'h02, K_RD = 6'h01;
  ////////////////////////////////
  // clock and instances
  always #20 sys_clk = ~sys_clk;
  bcm_core_model core (.sys_clk, .fetchReq, .fetchAddr, .dataReq, .dataWe, .dataAddr, .sfrWe, .sfrRe,
    .sfrAddr, .sfrWdata, .remapReq);
  bcm_mapper dut (.sys_clk, .rstn, .bootSelectPin, .fetchReq, .fetchAddr, .dataReq, .dataWe, .dataAddr,
    .sfrWe, .sfrRe, .sfrAddr, .sfrWdata, .remapReq, .flashBusy, .memLock, .fetchSel, .fetchValid,
    .dataFlashSel, .flashWrEn, .sfrRdata, .bootPhase, .ispRun, .jumpReq, .jumpAddr, .extAccessEn, .debugEn);
  ////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // expected fetch source; ROM wins over stub, stub over flash
  function automatic logic [1:0] expSel(input logic [15:0] a, input logic rom, stub, fl);
    if (rom && a <= BCM_ROM_LAST) return 2'h1;
    if (stub && a >= BCM_STUB_FIRST) return 2'h2;
    return fl ? 2'h3 : 2'h0;
  endfunction : expSel
  task automatic fchk(input logic [15:0] a, input logic rom, stub, fl);
    core.go(K_FETCH, a, 8'h00);
    chk(16'({fetchValid, fetchSel}), 16'({1'b1, expSel(a, rom, stub, fl)}));
  endtask : fchk
  // pin is set while reset is low so the latched boot choice is stable
  task automatic boot(input logic p);
    rstn = 1'b0;
    bootSelectPin = p;
    repeat (4) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : boot
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  ////////////////////////////////
  // hang guard, far beyond the roughly 80 cycles of the sequence
  initial begin
    #(40 * 3000);
    nMismatch++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(32'h7ECE));
    boot(1'b0);
    chk(16'({ispRun, bootPhase}), 16'(BCM_ENTRY));
    fchk(BCM_ROM_LAST, 1'b1, 1'b1, 1'b0);
    fchk(16'h4000, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) fchk(16'($urandom), 1'b1, 1'b1, 1'b0);
    core.go(K_DWR, 16'($urandom), 8'h00);
    chk(16'({dataFlashSel, flashWrEn}), 16'h0003);
    // a data read reaches flash but must not enable a write
    core.go(K_DRD, 16'($urandom), 8'h00);
    chk(16'({dataFlashSel, flashWrEn}), 16'h0002);
    core.go(K_REMAP, 16'h0000, 8'h00);
    chk(16'({jumpReq, bootPhase}), 16'h0007);
    chk(jumpAddr, BCM_APP_START);
    fchk(BCM_STUB_FIRST, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) fchk(16'($urandom), 1'b0, 1'b1, 1'b1);
    core.go(K_DWR, 16'h0100, 8'h00);
    chk(16'({dataFlashSel, flashWrEn}), 16'h0000);
    flashBusy = 1'($urandom);
    core.go(K_RD, 16'(BCM_CFG_ADDR), 8'h00);
    chk(16'(sfrRdata), 16'({BCM_CFG_RESET[7:2], flashBusy, 1'b0}));
    cfgVal = {1'b0, 4'($urandom), 3'h0};
    core.go(K_WR, 16'(BCM_CFG_ADDR), cfgVal);
    core.go(K_RD, 16'(BCM_CFG_ADDR), 8'h00);
    chk(16'(sfrRdata), 16'(cfgVal | {6'h00, flashBusy, 1'b0}));
    fchk(BCM_STUB_LAST, 1'b0, 1'b0, 1'b1);
    // other addresses are ignored on write and read back as zero
    core.go(K_WR, 16'h0080, 8'hFF);
    core.go(K_RD, 16'h0080, 8'h00);
    chk(16'(sfrRdata), 16'h0000);
    core.go(K_RD, 16'(BCM_CFG_ADDR), 8'h00);
    chk(16'(sfrRdata), 16'(cfgVal | {6'h00, flashBusy, 1'b0}));
    memLock = 1'b1;
    @(posedge sys_clk);
    #1 chk(16'({extAccessEn, debugEn}), 16'h0000);
    memLock = 1'b0;
    @(posedge sys_clk);
    #1 chk(16'({extAccessEn, debugEn}), 16'h0003);
    // mid-run reset brings back the boot map; pin high picks the programming routine
    boot(1'b1);
    chk(16'({ispRun, bootPhase}), 16'({1'b1, BCM_ISP}));
    fchk(16'h0100, 1'b1, 1'b1, 1'b0);
    fchk(BCM_STUB_LAST, 1'b1, 1'b1, 1'b0);
    core.go(K_RD, 16'(BCM_CFG_ADDR), 8'h00);
    chk(16'(sfrRdata), 16'({BCM_CFG_RESET[7:2], flashBusy, 1'b1}));
    core.go(K_REMAP, 16'h0000, 8'h00);
    chk(16'(jumpReq), 16'h0000);
    summarize();
  end
endmodule : boot_code_memory_mapper_tb
